// File: shared/cpr_pkg.sv
// Package for the configuration memory read port: constants and carrier types.
package cpr_pkg;

    // ****************************************
    // Geometry and reset values
    // ****************************************
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 8;
    localparam int          DEPTH        = 4096;
    localparam logic [11:0] ADDR_RST     = 12'h0000;
    localparam logic [11:0] TERM_COUNT   = 12'h0FFF;
    localparam logic [7:0]  DATA_RST     = 8'h00;

    // ****************************************
    // Test port
    // ****************************************
    localparam int          IR_W         = 4;
    localparam logic [3:0]  IR_BYPASS    = 4'hF;
    localparam logic [3:0]  IR_CONFIG    = 4'hE;
    localparam logic [3:0]  IR_IDCODE    = 4'h1;
    localparam logic [3:0]  IR_CAPTURE   = 4'h1;
    localparam int          ID_W         = 32;
    // Identification value is arbitrary.
    localparam logic [31:0] ID_VALUE     = 32'h1234_5671;

    // ****************************************
    // Timing: configuration-start pulse length
    // ****************************************
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          CFG_PULSE_NS    = 200;
    localparam int          CFG_PULSE_CYC   = (CFG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  CFG_PULSE_LAST  = 4'(CFG_PULSE_CYC - 1);

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } cpr_tap_t;

    // Open-drain and tristate pin carriers.
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
    } cpr_bus_t;

    typedef struct packed {
        logic o;
        logic oe;
    } cpr_pin_t;

endpackage

// File: hw/cpr_tap.sv
// Test access port: state machine, instruction and data registers.
module cpr_tap (
    input  wire logic tck_en,
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic tms,
    input  wire logic tdi,
    output logic      tdo_ff,
    output logic      tdo_oe_ff,
    output logic      config_cmd_ff
);

    cpr_pkg::cpr_tap_t state_ff;
    cpr_pkg::cpr_tap_t nxt_state;
    logic [3:0]        ir_ff;
    logic [3:0]        ir_sh_ff;
    logic [31:0]       dr_sh_ff;
    logic              nxt_tdo;

    // ****************************************
    // State transitions follow TMS on each rising test clock edge
    // ****************************************
    always_comb begin
        case (state_ff)
            cpr_pkg::TAP_RESET:  nxt_state = tms ? cpr_pkg::TAP_RESET  : cpr_pkg::TAP_IDLE;
            cpr_pkg::TAP_IDLE:   nxt_state = tms ? cpr_pkg::TAP_SEL_DR : cpr_pkg::TAP_IDLE;
            cpr_pkg::TAP_SEL_DR: nxt_state = tms ? cpr_pkg::TAP_SEL_IR : cpr_pkg::TAP_CAP_DR;
            cpr_pkg::TAP_CAP_DR: nxt_state = tms ? cpr_pkg::TAP_EX1_DR : cpr_pkg::TAP_SH_DR;
            cpr_pkg::TAP_SH_DR:  nxt_state = tms ? cpr_pkg::TAP_EX1_DR : cpr_pkg::TAP_SH_DR;
            cpr_pkg::TAP_EX1_DR: nxt_state = tms ? cpr_pkg::TAP_UPD_DR : cpr_pkg::TAP_PA_DR;
            cpr_pkg::TAP_PA_DR:  nxt_state = tms ? cpr_pkg::TAP_EX2_DR : cpr_pkg::TAP_PA_DR;
            cpr_pkg::TAP_EX2_DR: nxt_state = tms ? cpr_pkg::TAP_UPD_DR : cpr_pkg::TAP_SH_DR;
            cpr_pkg::TAP_UPD_DR: nxt_state = tms ? cpr_pkg::TAP_SEL_DR : cpr_pkg::TAP_IDLE;
            cpr_pkg::TAP_SEL_IR: nxt_state = tms ? cpr_pkg::TAP_RESET  : cpr_pkg::TAP_CAP_IR;
            cpr_pkg::TAP_CAP_IR: nxt_state = tms ? cpr_pkg::TAP_EX1_IR : cpr_pkg::TAP_SH_IR;
            cpr_pkg::TAP_SH_IR:  nxt_state = tms ? cpr_pkg::TAP_EX1_IR : cpr_pkg::TAP_SH_IR;
            cpr_pkg::TAP_EX1_IR: nxt_state = tms ? cpr_pkg::TAP_UPD_IR : cpr_pkg::TAP_PA_IR;
            cpr_pkg::TAP_PA_IR:  nxt_state = tms ? cpr_pkg::TAP_EX2_IR : cpr_pkg::TAP_PA_IR;
            cpr_pkg::TAP_EX2_IR: nxt_state = tms ? cpr_pkg::TAP_UPD_IR : cpr_pkg::TAP_SH_IR;
            cpr_pkg::TAP_UPD_IR: nxt_state = tms ? cpr_pkg::TAP_SEL_DR : cpr_pkg::TAP_IDLE;
            default:             nxt_state = cpr_pkg::TAP_RESET;
        endcase
    end

    assign nxt_tdo = (state_ff == cpr_pkg::TAP_SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff      <= cpr_pkg::TAP_RESET;
            ir_ff         <= cpr_pkg::IR_IDCODE;
            ir_sh_ff      <= cpr_pkg::IR_CAPTURE;
            dr_sh_ff      <= 32'h0000_0000;
            tdo_ff        <= 1'b1;
            tdo_oe_ff     <= 1'b0;
            config_cmd_ff <= 1'b0;
        end else begin
            config_cmd_ff <= 1'b0;
            // The output follows the shift register every cycle, so the first bit
            // stands before the first shifting test clock edge.
            tdo_oe_ff <= (state_ff == cpr_pkg::TAP_SH_IR) || (state_ff == cpr_pkg::TAP_SH_DR);
            tdo_ff    <= nxt_tdo;
            if (tck_en) begin
                state_ff  <= nxt_state;
                case (state_ff)
                    cpr_pkg::TAP_RESET:  ir_ff <= cpr_pkg::IR_IDCODE;
                    cpr_pkg::TAP_CAP_IR: ir_sh_ff <= cpr_pkg::IR_CAPTURE;
                    cpr_pkg::TAP_SH_IR:  ir_sh_ff <= {tdi, ir_sh_ff[3:1]};
                    cpr_pkg::TAP_UPD_IR: begin
                        ir_ff         <= ir_sh_ff;
                        config_cmd_ff <= (ir_sh_ff == cpr_pkg::IR_CONFIG);
                    end
                    cpr_pkg::TAP_CAP_DR: dr_sh_ff <= (ir_ff == cpr_pkg::IR_IDCODE) ? cpr_pkg::ID_VALUE : 32'h0000_0000;
                    cpr_pkg::TAP_SH_DR:  dr_sh_ff <= (ir_ff == cpr_pkg::IR_IDCODE) ? {tdi, dr_sh_ff[31:1]}
                                                                                 : {31'h0000_0000, tdi};
                    default: ;
                endcase
            end
        end
    end

endmodule

// File: hw/cpr_read_port.sv
// Read port of the configuration memory with cascade and test port.
//
// Contract
// - Address counter advances per rising memory clock in parallel mode, per eight in serial mode, while selected and enabled.
// - Output-enable low holds counter at reset and floats data, except a routed start pulse on data bit four.
// - Output-enable/reset is open-drain, device pulls it low while in reset.
// - Chip select high: standby, counter reset, data pins floated except a routed start pulse on data bit four.
// - Cascade output low only when selected, enabled and past terminal count.
// - Cascade output returns high when enable drops or select rises.
// - Test controller state follows TMS sampled on each TCK rising edge.
// - TDI feeds every test instruction and data register.
// - TDO shifts out every test instruction and data register.
// - Option routes configuration-start onto data bit four pin in serial mode.
// - Serial mode presents one bit at a time on data bit zero.
// - Parallel mode presents a byte on data bits zero to seven.
// - Data for the new address appears after each rising memory clock.
module cpr_read_port (
    input  wire logic                core_clk,
    input  wire logic                resetn,
    input  wire logic                mem_clk,
    input  wire logic                chip_sel_n,
    input  wire logic                oe_reset_n_i,
    input  wire logic                parallel_mode,
    input  wire logic                cfg_on_d4,
    input  wire logic                tck,
    input  wire logic                tms,
    input  wire logic                tdi,
    input  wire logic                wr_en,
    input  wire logic [11:0]         wr_addr,
    input  wire logic [7:0]          wr_data,
    output cpr_pkg::cpr_bus_t        data_ff,
    output logic                     oe_reset_n_o_ff,
    output logic                     oe_reset_n_oe_ff,
    output cpr_pkg::cpr_pin_t        config_start_n_ff,
    output logic                     cascade_select_out_n_ff,
    output logic                     tdo_ff,
    output logic                     tdo_oe_ff
);

    // ****************************************
    // Storage, counters and edge detection
    // ****************************************
    logic [7:0]  mem_ff [cpr_pkg::DEPTH];
    logic [11:0] addr_ff;
    logic [11:0] nxt_addr;
    logic        past_tc_ff;
    logic        mclk_d_ff;
    logic        tck_d_ff;
    logic [2:0]  bit_ff;
    logic [3:0]  cfg_cnt_ff;
    logic        cfg_busy_ff;
    logic        config_cmd;
    logic        tdo_w;
    logic        tdo_oe_w;
    logic        cfg_low;
    logic [2:0]  nxt_bit;

    wire         mclk_rise = mem_clk && !mclk_d_ff;
    wire         tck_rise  = tck && !tck_d_ff;
    wire         active    = !chip_sel_n && oe_reset_n_i;
    wire         at_tc     = (addr_ff == cpr_pkg::TERM_COUNT);
    wire         last_bit  = parallel_mode || (bit_ff == 3'h7);
    wire         step      = active && mclk_rise;
    wire         cf_pin4   = cfg_on_d4 && !parallel_mode;

    // Serial mode walks the bits of a byte before the address moves on, so one
    // memory clock equals one output bit; the counter then advances per byte.
    assign nxt_addr = (step && last_bit && !at_tc) ? addr_ff + 12'h001 : addr_ff;
    assign nxt_bit  = step ? bit_ff + 3'h1 : bit_ff;
    assign cfg_low  = config_cmd || cfg_busy_ff;

    cpr_tap cpr_tap_inst (
        .tck_en        (tck_rise),
        .core_clk      (core_clk),
        .resetn        (resetn),
        .tms           (tms),
        .tdi           (tdi),
        .tdo_ff        (tdo_w),
        .tdo_oe_ff     (tdo_oe_w),
        .config_cmd_ff (config_cmd)
    );

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mclk_d_ff  <= 1'b0;
            tck_d_ff   <= 1'b0;
            addr_ff    <= cpr_pkg::ADDR_RST;
            bit_ff     <= 3'h0;
            past_tc_ff <= 1'b0;
        end else begin
            mclk_d_ff <= mem_clk;
            tck_d_ff  <= tck;
            if (!active) begin
                addr_ff    <= cpr_pkg::ADDR_RST;
                bit_ff     <= 3'h0;
                past_tc_ff <= 1'b0;
            end else if (step) begin
                addr_ff    <= nxt_addr;
                bit_ff     <= parallel_mode ? 3'h0 : bit_ff + 3'h1;
                past_tc_ff <= past_tc_ff || (at_tc && last_bit);
            end
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            data_ff                 <= '{data: cpr_pkg::DATA_RST, oe: 8'h00};
            cascade_select_out_n_ff <= 1'b1;
            oe_reset_n_o_ff         <= 1'b0;
            oe_reset_n_oe_ff        <= 1'b1;
        end else begin
            oe_reset_n_o_ff  <= 1'b0;
            oe_reset_n_oe_ff <= 1'b0;
            cascade_select_out_n_ff <= !(active && (past_tc_ff || (step && at_tc && last_bit)));
            if (!active || past_tc_ff) begin
                data_ff <= '{data: cpr_pkg::DATA_RST, oe: 8'h00};
            end else if (parallel_mode) begin
                data_ff <= '{data: mem_ff[nxt_addr], oe: 8'hFF};
            end else begin
                data_ff <= '{data: {7'h00, mem_ff[nxt_addr][nxt_bit]},
                             oe: 8'h01};
            end
            // The routed start pulse overrides the data bit four lane, which is idle in serial mode.
            if (cf_pin4 && cfg_low) begin
                data_ff.data[4] <= 1'b0;
                data_ff.oe[4]   <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_cnt_ff        <= 4'h0;
            cfg_busy_ff       <= 1'b0;
            config_start_n_ff <= '{o: 1'b0, oe: 1'b0};
            tdo_ff            <= 1'b1;
            tdo_oe_ff         <= 1'b0;
        end else begin
            tdo_ff    <= tdo_w;
            tdo_oe_ff <= tdo_oe_w;
            if (config_cmd) begin
                cfg_busy_ff <= 1'b1;
                cfg_cnt_ff  <= 4'h0;
            end else if (cfg_busy_ff) begin
                cfg_busy_ff <= (cfg_cnt_ff != cpr_pkg::CFG_PULSE_LAST);
                cfg_cnt_ff  <= cfg_cnt_ff + 4'h1;
            end
            config_start_n_ff <= '{o: 1'b0, oe: cfg_low};
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    cas_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !active |=> cascade_select_out_n_ff) else $error("cascade low while idle");
    cas_early_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(cascade_select_out_n_ff) |-> $past(active) && $past(at_tc)) else $error("cascade early");
    addr_clr_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !active |=> addr_ff == cpr_pkg::ADDR_RST) else $error("counter not cleared");
    data_float_a: assert property (@(posedge core_clk) disable iff (!resetn)
        chip_sel_n |=> data_ff.oe == 8'h00) else $error("data driven in standby");
    addr_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
        step && parallel_mode && !at_tc |=> addr_ff == $past(addr_ff) + 12'h001) else $error("no step");
    addr_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        active && !mclk_rise |=> addr_ff == $past(addr_ff)) else $error("step without clock");
    ser_lane_a: assert property (@(posedge core_clk) disable iff (!resetn)
        active && !parallel_mode |=> data_ff.oe[7:1] == {3'h0, $past(cf_pin4 && cfg_low), 3'h0})
        else $error("serial lane");
    par_lane_a: assert property (@(posedge core_clk) disable iff (!resetn)
        active && parallel_mode && !past_tc_ff |=> data_ff.oe == 8'hFF) else $error("parallel lane");
    cfg_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
        config_cmd |=> config_start_n_ff.oe [*5]) else $error("start pulse short");
    oe_od_a: assert property (@(posedge core_clk) disable iff (!resetn)
        oe_reset_n_o_ff == 1'b0) else $error("open drain drives high");

endmodule

// File: test/cpr_cfg_master.sv
// Model of the configuration master that clocks the memory and captures its data.
module cpr_cfg_master (
    input  wire logic              core_clk,
    input  wire cpr_pkg::cpr_bus_t data_ff,
    input  wire logic              cascade_select_out_n_ff,
    output logic                   mem_clk,
    output logic                   next_cs_n,
    output cpr_pkg::cpr_bus_t      cap
);
    timeunit 1ns;
    timeprecision 1ps;

    // The next memory in the chain is selected by this one's cascade output.
    assign next_cs_n = cascade_select_out_n_ff;

    initial begin
        mem_clk = 1'b0;
        cap = '0;
    end

    // One clock pulse, two core cycles high and two low, so edges never crowd the sampler.
    task automatic step();
        @(posedge core_clk);
        #1;
        cap = data_ff;
        mem_clk = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        mem_clk = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
endmodule

// File: test/tb_cpr_read_port.sv
// Self-checking testbench for the configuration memory read port.
module tb_cpr_read_port;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        int          sel;
        logic [15:0] exp;
        string       name;
    } cpr_note_t;

    logic              core_clk;
    logic              resetn;
    logic              mem_clk;
    logic              chip_sel_n;
    logic              fpga_low;
    logic              parallel_mode;
    logic              cfg_on_d4;
    logic              tck;
    logic              tms;
    logic              tdi;
    logic              wr_en;
    logic [11:0]       wr_addr;
    logic [7:0]        wr_data;
    logic              oe_line;
    cpr_pkg::cpr_bus_t data_ff;
    cpr_pkg::cpr_bus_t cap;
    logic              oe_o;
    logic              oe_oe;
    cpr_pkg::cpr_pin_t cfg_pin;
    logic              casc_n;
    logic              next_cs_n;
    logic              tdo;
    logic              tdo_oe;
    logic [15:0]       meas;
    logic [7:0]        mem [cpr_pkg::DEPTH];
    cpr_note_t         notes[$];
    int                n_fail;
    int                checked;
    int                w;

    // Open-drain reset line with pull-up: low if either side pulls it.
    assign oe_line = ((oe_oe && !oe_o) || fpga_low) ? 1'b0 : 1'b1;

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    cpr_read_port cpr_read_port_inst (.core_clk(core_clk), .resetn(resetn), .mem_clk(mem_clk),
        .chip_sel_n(chip_sel_n), .oe_reset_n_i(oe_line), .parallel_mode(parallel_mode),
        .cfg_on_d4(cfg_on_d4), .tck(tck), .tms(tms), .tdi(tdi), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .data_ff(data_ff), .oe_reset_n_o_ff(oe_o), .oe_reset_n_oe_ff(oe_oe),
        .config_start_n_ff(cfg_pin), .cascade_select_out_n_ff(casc_n), .tdo_ff(tdo), .tdo_oe_ff(tdo_oe));

    cpr_cfg_master cpr_cfg_master_inst (.core_clk(core_clk), .data_ff(data_ff),
        .cascade_select_out_n_ff(casc_n), .mem_clk(mem_clk), .next_cs_n(next_cs_n), .cap(cap));

    // ****************************************
    // Notes, watcher and verdict
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic note(input int sel, input logic [15:0] exp, input string name);
        notes.push_back('{sel, exp, name});
    endtask

    function automatic logic [15:0] obs(input int sel);
        case (sel)
            0: return {15'h0000, casc_n};
            1: return {15'h0000, oe_oe};
            2: return {14'h0000, cfg_pin};
            3: return {14'h0000, tdo_oe, tdo};
            4: return {8'h00, data_ff.oe};
            5: return data_ff;
            6: return cap;
            7: return {14'h0000, data_ff.oe[0], data_ff.data[0]};
            8: return {15'h0000, next_cs_n};
            default: return meas;
        endcase
    endfunction

    // Outputs are settled by the falling edge, half a cycle after the driver noted its wish.
    always @(negedge core_clk) begin
        while (notes.size() > 0) begin
            cpr_note_t n;
            n = notes.pop_front();
            checked++;
            if (obs(n.sel) !== n.exp) begin
                $display("Error %s expected %h seen %h", n.name, n.exp, obs(n.sel));
                n_fail++;
            end
        end
    end

    task automatic test_done();
        $display("Checks %0d, errors %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tap(input logic m, input logic d, input logic chk, input logic e);
        tms = m;
        tdi = d;
        cyc(3);
        if (chk)
            note(3, {14'h0000, 1'b1, e}, "tdo");
        tck = 1'b1;
        cyc(3);
        tck = 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h8d43_981e));
        {resetn, fpga_low, cfg_on_d4, tck, tdi, wr_en, chip_sel_n, parallel_mode, tms} = 9'h007;
        {wr_addr, wr_data, meas, n_fail, checked} = '0;
        cyc(5);
        note(1, 16'h0001, "reset_pin_oe");
        note(0, 16'h0001, "cascade");
        note(4, 16'h0000, "data_oe");
        cyc(5);
        resetn = 1'b1;
        cyc(2);
        note(1, 16'h0000, "reset_pin_oe");
        wr_en = 1'b1;
        for (int a = 0; a < cpr_pkg::DEPTH; a++) begin
            mem[a] = 8'($urandom);
            wr_addr = 12'(a);
            wr_data = mem[a];
            cyc(1);
        end
        wr_en = 1'b0;
        chip_sel_n = 1'b0;
        cyc(2);
        note(5, {mem[0], 8'hFF}, "byte");
        for (int i = 1; i < 6; i++) begin
            cpr_cfg_master_inst.step();
            note(6, {mem[i - 1], 8'hFF}, "captured");
            note(5, {mem[i], 8'hFF}, "byte");
        end
        // Clock pulses while deselected or held in reset must not move the counter.
        for (int k = 0; k < 2; k++) begin
            chip_sel_n = (k == 0);
            fpga_low = (k == 1);
            cyc(2);
            note(4, 16'h0000, "data_oe");
            repeat (3) cpr_cfg_master_inst.step();
            {chip_sel_n, fpga_low} = 2'b00;
            cyc(2);
            note(5, {mem[0], 8'hFF}, "byte");
        end
        for (int k = 0; k < 2; k++) begin
            repeat (cpr_pkg::DEPTH - 1) cpr_cfg_master_inst.step();
            note(5, {mem[cpr_pkg::DEPTH - 1], 8'hFF}, "last_byte");
            note(0, 16'h0001, "cascade");
            cpr_cfg_master_inst.step();
            note(0, 16'h0000, "cascade");
            note(4, 16'h0000, "data_oe");
            note(8, 16'h0000, "next_select");
            chip_sel_n = (k == 0);
            fpga_low = (k == 1);
            cyc(2);
            note(0, 16'h0001, "cascade");
            {chip_sel_n, fpga_low} = 2'b00;
            cyc(2);
        end
        chip_sel_n = 1'b1;
        parallel_mode = 1'b0;
        cfg_on_d4 = 1'($urandom);
        cyc(2);
        chip_sel_n = 1'b0;
        cyc(2);
        for (int b = 0; b < 2; b++) begin
            for (int j = 0; j < 8; j++) begin
                note(7, {14'h0000, 1'b1, mem[b][j]}, "serial_bit");
                cpr_cfg_master_inst.step();
            end
        end
        // Walk the test controller to Shift-IR, load the start instruction, then Update-IR.
        tap(1'b0, 1'b0, 1'b0, 1'b0);
        tap(1'b1, 1'b0, 1'b0, 1'b0);
        tap(1'b1, 1'b0, 1'b0, 1'b0);
        tap(1'b0, 1'b0, 1'b0, 1'b0);
        tap(1'b0, 1'b0, 1'b0, 1'b0);
        for (int j = 0; j < cpr_pkg::IR_W; j++)
            tap(j == cpr_pkg::IR_W - 1, cpr_pkg::IR_CONFIG[j], 1'b1, cpr_pkg::IR_CAPTURE[j]);
        tap(1'b1, 1'b0, 1'b0, 1'b0);
        // Leaving Update-IR on this test clock edge issues the start instruction.
        tms = 1'b0;
        cyc(3);
        tck = 1'b1;
        w = 0;
        while (cfg_pin.oe !== 1'b1 && w < 50) begin
            cyc(1);
            w++;
        end
        if (w >= 50) begin
            n_fail++;
            test_done();
        end
        note(2, 16'h0001, "config_start");
        note(4, {8'h00, 3'h0, cfg_on_d4, 4'h1}, "d4_route");
        while (cfg_pin.oe === 1'b1 && meas < 16'h0064) begin
            cyc(1);
            meas++;
        end
        tck = 1'b0;
        note(9, 16'(cpr_pkg::CFG_PULSE_CYC + 1), "pulse_len");
        cyc(2);
        test_done();
    end
endmodule
